// *** hw/adc_serial_port_control.sv ***
`timescale 1ns/1ns
`default_nettype none

// Contract
// [RULE_01] Serial input bits assemble in a shift register, then land in the selected register.
// [RULE_02] Active-low reset pin returns all control, interface and register state to power-on.
// [RULE_03] Serial transfers are honoured only while chip select is low.
// [RULE_04] Chip select tied low gives a three-wire port of clock, input and output.
// [RULE_05] Host may use chip select to pick one converter or to frame transfers.
// [RULE_06] Host supplies the serial clock; the device only reacts to arriving edges.
// [RULE_07] A word may arrive as one unbroken train of clock pulses.
// [RULE_08] Clock may pause between bit groups; shift position is kept across pauses.
// [RULE_09] Filter sync input lets several converters start conversions together.
// [RULE_10] Sync low holds filter nodes, filter control and calibration control in reset.
// [RULE_11] Sync low holds the modulator in reset until the input returns high.
// [RULE_12] Host writes the communications byte before each data transfer.
// [RULE_13] Idle level pin high means first clock transition falls, low means it rises.
// [RULE_14] Result waiting output goes low when a fresh word sits in the data register.
// [RULE_15] Result waiting goes high after a full read and just before an overwrite.
// [RULE_16] Read data leaves through an output shift register loaded from the selected register.
module adc_serial_port_control
  import adc_serial_port_pkg::*;
(
  input  wire logic              clk,                  // Core clock, 50 MHz.
  input  wire logic              reset,                // Synchronous reset, active high.
  input  wire logic              ce,                   // Core clock enable.
  input  wire logic              sclk,                 // Serial clock from the host.
  input  wire logic              cs_n,                 // Chip select, active low.
  input  wire logic              din,                  // Serial data in.
  output logic                   dout,                 // Serial data out.
  output logic                   dout_oe,              // High while dout is driven.
  input  wire logic              reset_n,              // Reset pin, active low.
  input  wire logic              sync_n,               // Filter sync pin, active low.
  input  wire logic              clock_idle_level_pin, // Serial clock idle level strap.
  output logic                   result_waiting_n,     // Fresh result waiting, active low.
  input  wire logic              conv_valid,           // Conversion result offered.
  output logic                   conv_ready,           // Conversion result taken.
  input  wire logic [WORD_W-1:0] conv_data,            // Conversion result.
  output logic                   filter_hold,          // Filter and calibration control held.
  output logic                   modulator_hold        // Modulator held in reset.
);

  // Core-domain synchronisers for the pins and for the link-domain busy flag and toggles.
  logic rst_pin_s1_ff, rst_pin_s2_ff, sync_s1_ff, sync_s2_ff, cs_s1_ff, cs_s2_ff;
  logic pol_s1_ff, pol_s2_ff, busy_s1_ff, busy_s2_ff;
  logic wr_s1_ff, wr_s2_ff, wr_seen_ff, rd_s1_ff, rd_s2_ff, rd_seen_ff;
  logic core_rst, link_clr_ff, link_rst_ff;

  // Link-domain state.
  logic              samp_clk;
  link_phase_t       phase_ff;
  logic [CNT_W-1:0]  bit_cnt_ff;
  logic [WORD_W-1:0] in_sr_ff;
  logic [SEL_W-1:0]  sel_ff;
  logic              busy_ff;
  logic              wr_tog_ff, rd_tog_ff;
  wr_word_t          wr_hold_ff;
  logic [WORD_W-1:0] out_sr_ff;
  logic              last_bit;
  logic [COMM_W-1:0] comm_byte;

  // Core state.
  logic [WORD_W-1:0] regs_ff [REG_N];
  wr_word_t          fifo_ff [FIFO_DEPTH];
  logic              fifo_wp_ff;
  logic              fifo_rp_ff;
  logic [1:0]        fifo_cnt_ff;
  logic              fifo_push, fifo_pop, wr_evt, rd_evt;
  result_state_t     res_state_ff;
  logic [3:0]        upd_cnt_ff;
  logic [WORD_W-1:0] pend_ff;
  logic              conv_take, upd_done;

  always_ff @(posedge clk)
  begin
    rst_pin_s1_ff <= reset_n;
    rst_pin_s2_ff <= rst_pin_s1_ff;
    sync_s1_ff    <= sync_n;
    sync_s2_ff    <= sync_s1_ff;
    cs_s1_ff      <= cs_n;
    cs_s2_ff      <= cs_s1_ff;
    pol_s1_ff     <= clock_idle_level_pin;
    pol_s2_ff     <= pol_s1_ff;
    busy_s1_ff    <= busy_ff;
    busy_s2_ff    <= busy_s1_ff;
    wr_s1_ff      <= wr_tog_ff;
    wr_s2_ff      <= wr_s1_ff;
    rd_s1_ff      <= rd_tog_ff;
    rd_s2_ff      <= rd_s1_ff;
  end

  assign core_rst = reset || !rst_pin_s2_ff; // RULE_02

  // Link logic is cleared while deselected or in reset; the clear is a flop so it cannot glitch.
  always_ff @(posedge clk)
  begin
    link_rst_ff <= core_rst;
    link_clr_ff <= core_rst || cs_s2_ff; // RULE_03
  end

  // Data is taken on the second transition of each bit and driven on the first. The strap is a
  // static level, so the clock select only glitches if the board changes it while running.
  assign samp_clk = pol_s2_ff ? sclk : ~sclk; // RULE_13

  assign last_bit = (phase_ff == PH_COMM) ? (bit_cnt_ff == COMM_LAST) : (bit_cnt_ff == WORD_LAST);
  assign comm_byte = {in_sr_ff[COMM_W-2:0], din};

  // Position survives any pause in the clock because nothing here runs without an edge.
  always_ff @(posedge samp_clk or posedge link_clr_ff)
  begin
    if (link_clr_ff)
    begin
      phase_ff   <= PH_COMM;
      bit_cnt_ff <= CNT_ZERO;
      in_sr_ff   <= REG_RESET;
      sel_ff     <= DATA_IDX;
      busy_ff    <= 1'b0;
    end
    else if (!cs_n) // RULE_04
    begin
      in_sr_ff <= {in_sr_ff[WORD_W-2:0], din}; // RULE_01
      busy_ff  <= !(last_bit && (phase_ff != PH_COMM));
      if (last_bit) // RULE_07 RULE_08
      begin
        bit_cnt_ff <= CNT_ZERO;
        if (phase_ff == PH_COMM)
        begin
          sel_ff   <= comm_byte[COMM_SEL_LSB +: SEL_W];
          phase_ff <= comm_byte[COMM_RD_BIT] ? PH_READ : PH_WRITE;
        end
        else
        begin
          phase_ff <= PH_COMM;
        end
      end
      else
      begin
        bit_cnt_ff <= bit_cnt_ff + CNT_ONE;
      end
    end
  end

  // Toggles only clear with the core reset, so deselecting the device never fakes an event.
  always_ff @(posedge samp_clk or posedge link_rst_ff)
  begin
    if (link_rst_ff)
    begin
      wr_tog_ff  <= 1'b0;
      rd_tog_ff  <= 1'b0;
      wr_hold_ff <= '0;
    end
    else if (!cs_n && last_bit)
    begin
      if (phase_ff == PH_WRITE)
      begin
        wr_hold_ff <= '{addr: sel_ff, data: {in_sr_ff[WORD_W-2:0], din}}; // RULE_01
        wr_tog_ff  <= ~wr_tog_ff;
      end
      if (phase_ff == PH_READ && sel_ff == DATA_IDX)
      begin
        rd_tog_ff <= ~rd_tog_ff; // RULE_15
      end
    end
  end

  // The register bank is read across domains; the core holds buffered writes while busy is seen, but an update already under way still fills the data register.
  always_ff @(negedge samp_clk or posedge link_clr_ff)
  begin
    if (link_clr_ff)
      out_sr_ff <= REG_RESET;
    else if (phase_ff == PH_READ)
    begin
      if (bit_cnt_ff == CNT_ZERO)
        out_sr_ff <= regs_ff[sel_ff]; // RULE_16
      else
        out_sr_ff <= {out_sr_ff[WORD_W-2:0], 1'b0}; // RULE_16
    end
  end

  assign dout    = out_sr_ff[WORD_W-1];
  assign dout_oe = (phase_ff == PH_READ);

  // Written words wait in a two-entry buffer until no transfer is in flight.
  assign wr_evt    = wr_s2_ff ^ wr_seen_ff;
  assign rd_evt    = rd_s2_ff ^ rd_seen_ff;
  assign fifo_push = ce && wr_evt && (fifo_cnt_ff != FIFO_FULL_CNT);
  assign fifo_pop  = ce && !busy_s2_ff && (fifo_cnt_ff != FIFO_EMPTY_CNT);

  always_ff @(posedge clk)
  begin
    if (core_rst)
    begin
      wr_seen_ff  <= 1'b0;
      fifo_wp_ff  <= 1'b0;
      fifo_rp_ff  <= 1'b0;
      fifo_cnt_ff <= FIFO_EMPTY_CNT;
    end
    else
    begin
      if (fifo_push)
      begin
        fifo_ff[fifo_wp_ff] <= wr_hold_ff;
        fifo_wp_ff          <= ~fifo_wp_ff;
        wr_seen_ff          <= wr_s2_ff;
      end
      if (fifo_pop)
      begin
        fifo_rp_ff <= ~fifo_rp_ff;
      end
      if (fifo_push && !fifo_pop)
        fifo_cnt_ff <= fifo_cnt_ff + FIFO_ONE;
      else if (fifo_pop && !fifo_push)
        fifo_cnt_ff <= fifo_cnt_ff - FIFO_ONE;
    end
  end

  // The data register is read-only from the serial side; only conversions fill it.
  always_ff @(posedge clk)
  begin
    if (core_rst)
    begin
      for (int i = 0; i < REG_N; i++)
      begin
        regs_ff[i] <= REG_RESET; // RULE_02
      end
    end
    else if (ce)
    begin
      if (fifo_pop && fifo_ff[fifo_rp_ff].addr != DATA_IDX)
      begin
        regs_ff[fifo_ff[fifo_rp_ff].addr] <= fifo_ff[fifo_rp_ff].data; // RULE_01
      end
      if (upd_done)
      begin
        regs_ff[DATA_IDX] <= pend_ff;
      end
    end
  end

  // Filter, calibration control and modulator share the held sync level.
  always_ff @(posedge clk)
  begin
    if (core_rst)
    begin
      filter_hold    <= 1'b1;
      modulator_hold <= 1'b1;
    end
    else if (ce)
    begin
      filter_hold    <= !sync_s2_ff; // RULE_09 RULE_10
      modulator_hold <= !sync_s2_ff; // RULE_11
    end
  end

  assign conv_ready = ce && !core_rst && !filter_hold && !busy_s2_ff && (res_state_ff != RW_UPDATE);
  assign conv_take  = conv_valid && conv_ready;
  assign upd_done   = (res_state_ff == RW_UPDATE) && (upd_cnt_ff == UPD_ZERO);

  // A new result wins over a read completing in the same cycle, so it is never lost.
  always_ff @(posedge clk)
  begin
    if (core_rst)
    begin
      res_state_ff <= RW_EMPTY;
      upd_cnt_ff   <= UPD_ZERO;
      pend_ff      <= REG_RESET;
      rd_seen_ff   <= 1'b0;
    end
    else if (ce)
    begin
      rd_seen_ff <= rd_s2_ff;
      unique case (res_state_ff)
        RW_EMPTY, RW_FRESH:
        begin
          if (conv_take)
          begin
            pend_ff      <= conv_data;
            upd_cnt_ff   <= UPDATE_CYC - UPD_ONE;
            res_state_ff <= RW_UPDATE; // RULE_15
          end
          else if (rd_evt)
          begin
            res_state_ff <= RW_EMPTY; // RULE_15
          end
        end
        RW_UPDATE:
        begin
          if (upd_done)
          begin
            res_state_ff <= RW_FRESH; // RULE_14
          end
          else
          begin
            upd_cnt_ff <= upd_cnt_ff - UPD_ONE;
          end
        end
      endcase
    end
  end

  assign result_waiting_n = (res_state_ff != RW_FRESH); // RULE_14

  chk_fifo_bound: assert property (@(posedge clk) disable iff (core_rst) fifo_cnt_ff <= FIFO_FULL_CNT) // RULE_01
    else $error("write buffer count exceeds depth");
  chk_write_lands: assert property (@(posedge clk) disable iff (core_rst) // RULE_01
    fifo_pop && fifo_ff[fifo_rp_ff].addr != DATA_IDX |=> regs_ff[$past(fifo_ff[fifo_rp_ff].addr)] ==
    $past(fifo_ff[fifo_rp_ff].data) || !$past(ce))
    else $error("written word did not reach its register");
  chk_reset_clears: assert property (@(posedge clk) core_rst |=> regs_ff[DATA_IDX] == REG_RESET // RULE_02
    && result_waiting_n && filter_hold)
    else $error("reset left state behind");
  chk_deselect_clears: assert property (@(posedge clk) disable iff (reset) cs_s2_ff |=> link_clr_ff) // RULE_03
    else $error("deselect did not clear the link");
  chk_sync_holds: assert property (@(posedge clk) disable iff (core_rst) !sync_s2_ff && ce |=> filter_hold // RULE_10
    && !conv_ready)
    else $error("filter not held while sync low");
  chk_mod_release: assert property (@(posedge clk) disable iff (core_rst) // RULE_11
    $rose(sync_s2_ff) && ce |=> !modulator_hold)
    else $error("modulator not released after sync");
  chk_fresh_low: assert property (@(posedge clk) disable iff (core_rst) // RULE_14
    upd_done && ce |=> !result_waiting_n)
    else $error("fresh result not flagged");
  chk_update_gap: assert property (@(posedge clk) disable iff (core_rst) // RULE_15
    conv_take |=> result_waiting_n [*4])
    else $error("flag not high before overwrite");
  chk_read_clears: assert property (@(posedge clk) disable iff (core_rst) // RULE_15
    rd_evt && ce && !conv_take && res_state_ff == RW_FRESH |=> result_waiting_n)
    else $error("flag not raised after full read");
  chk_read_drive: assert property (@(posedge samp_clk) disable iff (link_clr_ff) // RULE_16
    !cs_n && last_bit && phase_ff == PH_COMM && comm_byte[COMM_RD_BIT] |=> dout_oe)
    else $error("read command did not start driving data out");

endmodule

`default_nettype wire

// *** hw/adc_serial_port_pkg.sv ***
package adc_serial_port_pkg;

  localparam int WORD_W = 24;
  localparam int COMM_W = 8;
  localparam int REG_N = 8;
  localparam int SEL_W = 3;
  localparam int CNT_W = 5;

  // Layout of the communications byte.
  localparam int COMM_RD_BIT = 7;
  localparam int COMM_SEL_LSB = 0;

  localparam logic [SEL_W-1:0] DATA_IDX = 3'h3;
  localparam logic [WORD_W-1:0] REG_RESET = 24'h000000;
  localparam logic [CNT_W-1:0] CNT_ZERO = 5'h00;
  localparam logic [CNT_W-1:0] CNT_ONE = 5'h01;
  localparam logic [CNT_W-1:0] COMM_LAST = 5'h07;
  localparam logic [CNT_W-1:0] WORD_LAST = 5'h17;

  // Time the result flag stays high before the data register is overwritten.
  localparam int CLK_NS = 20;
  localparam int UPDATE_NS = 100;
  localparam int UPDATE_CYC_I = (UPDATE_NS / CLK_NS) < 1 ? 1 : (UPDATE_NS / CLK_NS);
  localparam logic [3:0] UPDATE_CYC = 4'(UPDATE_CYC_I);
  localparam logic [3:0] UPD_ZERO = 4'h0;
  localparam logic [3:0] UPD_ONE = 4'h1;

  localparam int FIFO_DEPTH = 2;
  localparam logic [1:0] FIFO_FULL_CNT = 2'h2;
  localparam logic [1:0] FIFO_EMPTY_CNT = 2'h0;
  localparam logic [1:0] FIFO_ONE = 2'h1;

  typedef enum logic [1:0] {PH_COMM, PH_WRITE, PH_READ} link_phase_t;
  typedef enum logic [1:0] {RW_EMPTY, RW_UPDATE, RW_FRESH} result_state_t;

  typedef struct packed {
    logic [SEL_W-1:0]  addr;
    logic [WORD_W-1:0] data;
  } wr_word_t;

endpackage

// *** tb/host_serial_model.sv ***
`timescale 1ns/1ns
`default_nettype none

module host_serial_model (
  input  wire logic strap,   // Idle level of the serial clock.
  input  wire logic dout,    // Serial data from the device.
  input  wire logic dout_oe, // Drive enable from the device.
  output logic      sclk,    // Serial clock, still outside frames.
  output logic      cs_n,    // Chip select, active low.
  output logic      din      // Serial data to the device.
);
  localparam int HALF_NS = 80;
  bit three_wire = 1'b0;
  bit busy       = 1'b0;
  int oe_high    = 0;

  initial
  begin
    sclk = 1'b0;
    cs_n = 1'b1;
    din  = 1'b0;
  end

  always @(strap)
    if (!busy)
      sclk = strap;

  // One comm byte and one word, MSB first; pause_at stretches the clock after that bit.
  task automatic xfer(input bit sel, input logic [31:0] frame, input int pause_at, output logic [23:0] rdata);
    rdata   = '0;
    oe_high = 0;
    busy    = 1'b1;
    #7;
    cs_n = !sel;
    #(HALF_NS * 2);
    for (int i = 31; i >= 0; i--)
    begin
      din  = frame[i];
      sclk = ~strap;
      #(HALF_NS);
      if (i < 24)
      begin
        rdata[i] = dout;
        oe_high  = oe_high + int'(dout_oe);
      end
      sclk = strap;
      #(HALF_NS);
      if (i == pause_at)
        #(HALF_NS * 6);
    end
    // The released line must not keep showing the last bit.
    din = ~din;
    if (!three_wire)
      cs_n = 1'b1;
    #(HALF_NS * 4);
    busy = 1'b0;
  endtask
endmodule

`default_nettype wire

// *** tb/tb_top.sv ***
`timescale 1ns/1ns
`default_nettype none

module tb_top;
  import adc_serial_port_pkg::*;
  logic              clk;
  logic              reset;
  logic              ce;
  logic              reset_n;
  logic              sync_n;
  logic              strap;
  logic              conv_valid;
  logic [WORD_W-1:0] conv_data;
  logic [WORD_W-1:0] rd;
  wire logic         sclk, cs_n, din, dout, dout_oe, rw_n, conv_ready, f_hold, m_hold;
  int                err_total    = 0;
  int                total_checks = 0;
  int                cycles       = 0;

  adc_serial_port_control i_adc_serial_port_control (
    .clk(clk), .reset(reset), .ce(ce), .sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout),
    .dout_oe(dout_oe), .reset_n(reset_n), .sync_n(sync_n), .clock_idle_level_pin(strap),
    .result_waiting_n(rw_n), .conv_valid(conv_valid), .conv_ready(conv_ready),
    .conv_data(conv_data), .filter_hold(f_hold), .modulator_hold(m_hold));

  host_serial_model i_host_serial_model (
    .strap(strap), .dout(dout), .dout_oe(dout_oe), .sclk(sclk), .cs_n(cs_n), .din(din));

  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
    total_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wait_clk(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic reg_write(input logic [2:0] sel, input logic [23:0] d, input int pause_at, input bit cs = 1'b1);
    i_host_serial_model.xfer(cs, {1'b0, 4'h0, sel, d}, pause_at, rd);
    check("drive enable on write", 24'h000000, 24'(i_host_serial_model.oe_high));
    wait_clk(12);
  endtask

  task automatic reg_read(input logic [2:0] sel, input logic [23:0] exp, input int pause_at);
    i_host_serial_model.xfer(1'b1, {1'b1, 4'h0, sel, 24'h000000}, pause_at, rd);
    check("read word", exp, rd);
    check("drive enable bits", 24'h000018, 24'(i_host_serial_model.oe_high));
    wait_clk(12);
  endtask

  task automatic conv_send(input logic [23:0] d);
    conv_data  = d;
    conv_valid = 1'b1;
    #1;
    for (int i = 0; i < 50 && conv_ready !== 1'b1; i++)
      @(negedge clk);
    check("conv accepted", 24'h000001, {23'h0, conv_ready});
    @(posedge clk);
    @(negedge clk);
    conv_valid = 1'b0;
  endtask

  task automatic wait_fresh();
    for (int i = 0; i < 20 && rw_n !== 1'b0; i++)
      @(negedge clk);
    check("result waiting low", 24'h000000, {23'h0, rw_n});
  endtask

  task automatic t_write_read();
    reg_write(3'h1, 24'hA5C396, -1);
    reg_read(3'h1, 24'hA5C396, -1);
    reg_write(3'h2, 24'h3C0F81, 20);
    reg_read(3'h2, 24'h3C0F81, 5);
    strap = 1'b0;
    wait_clk(10);
    reg_write(3'h4, 24'h5A0F31, 12);
    reg_read(3'h4, 24'h5A0F31, -1);
    strap = 1'b1;
    wait_clk(10);
    $display("test write_read done");
  endtask

  task automatic t_cs_refused();
    reg_write(3'h1, 24'h000000, -1, 1'b0);
    reg_read(3'h1, 24'hA5C396, -1);
    i_host_serial_model.three_wire = 1'b1;
    reg_write(3'h5, 24'h123456, -1);
    i_host_serial_model.three_wire = 1'b0;
    reg_read(3'h5, 24'h123456, -1);
    $display("test cs_refused done");
  endtask

  task automatic t_conv();
    conv_send(24'hC0FFEE);
    wait_fresh();
    conv_send(24'h0BEEF7);
    check("overwrite warning", 24'h000001, {23'h0, rw_n});
    wait_fresh();
    reg_read(DATA_IDX, 24'h0BEEF7, -1);
    check("high after read", 24'h000001, {23'h0, rw_n});
    reg_write(DATA_IDX, 24'h111111, -1);
    reg_read(DATA_IDX, 24'h0BEEF7, -1);
    $display("test conv done");
  endtask

  task automatic t_sync_reset();
    sync_n = 1'b0;
    wait_clk(6);
    check("holds in sync", 24'h000003, {22'h0, f_hold, m_hold});
    check("no conv in sync", 24'h000000, {23'h0, conv_ready});
    sync_n = 1'b1;
    wait_clk(6);
    check("holds released", 24'h000000, {22'h0, f_hold, m_hold});
    ce     = 1'b0;
    sync_n = 1'b0;
    wait_clk(6);
    check("frozen while disabled", 24'h000000, {22'h0, f_hold, conv_ready});
    ce     = 1'b1;
    sync_n = 1'b1;
    wait_clk(6);
    reset_n = 1'b0;
    wait_clk(6);
    reset_n = 1'b1;
    wait_clk(10);
    reg_read(3'h1, REG_RESET, -1);
    reg_read(3'h5, REG_RESET, -1);
    $display("test sync_reset done");
  endtask

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      err_total++;
      $display("[FAIL] run length expected below 30000 seen %0d", cycles);
      finish_test();
    end
  end

  initial
  begin
    reset      = 1'b1;
    ce         = 1'b1;
    reset_n    = 1'b1;
    sync_n     = 1'b1;
    strap      = 1'b1;
    conv_valid = 1'b0;
    conv_data  = '0;
    rd         = '0;
    wait_clk(12);
    reset = 1'b0;
    wait_clk(10);
    t_write_read();
    t_cs_refused();
    t_conv();
    t_sync_reset();
    finish_test();
  end
endmodule

`default_nettype wire
